/* File: dv/iep_src_model.sv */
// model of the peripheral sources that raise pending flags
`timescale 1ns/10ps
`default_nettype none
module iep_src_model
  import iep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [NUM_SRC-1:0] flagWant,
  output logic [NUM_SRC-1:0] srcFlag
);
  // flags are levels that move only just after an edge, as a real peripheral's do
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      srcFlag <= '0;
    end else begin
      srcFlag <= flagWant;
    end
  end
endmodule // iep_src_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the enable and priority control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import iep_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} iep_row_t;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, coreRequest, irqOut, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] coreLevel;
  logic [NUM_SRC-1:0] srcFlag, srcRequest, flagWant;
  int failures = 0;
  int cmp_count = 0;
  iep_row_t rows[8];
  logic [15:0] rstVal[6];

  iep_src_model i_iep_src_model (.sys_clk(sys_clk), .reset_n(reset_n), .flagWant(flagWant), .srcFlag(srcFlag));
  iep_ctrl i_iep_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srcFlag(srcFlag), .srcRequest(srcRequest), .coreRequest(coreRequest), .coreLevel(coreLevel),
    .irqOut(irqOut));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // bus and checking tasks
  // ----------------------------------------
  // one edge passes before setup so back-to-back calls never drive a signal twice at once
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no wait-state limit here: a slave that never answers is caught by the watchdog
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #20us;
    failures++;
    stop_test;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, flagWant} = '0;
    pstrb = 4'hF;
    reset_n = 1'b0;
    rows = '{'{32'(OFF_ENABLE2), 32'hFFFF, 32'h4006}, '{32'(OFF_ENABLE3), 32'hFFFF, 32'h210E},
      '{32'(OFF_ENABLE5), 32'hFFFF, 32'h0040}, '{32'(OFF_PRIO0), 32'hFFFF, 32'h7777},
      '{32'(OFF_PRIO1), 32'hFFFF, 32'h7770}, '{32'(OFF_PRIO2), 32'hFFFF, 32'h7777},
      '{32'(OFF_PRIO2), 32'h8A5C, 32'h0254}, '{32'(OFF_ENABLE3), 32'h2101, 32'h2100}};
    rstVal = '{16'h0000, 16'h0000, 16'h0000, 16'h4444, 16'h4440, 16'h4444};
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    // mid-run reset brings back power-on values
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, {16'h0, rstVal[i]});
    end
    apb(1'b1, 32'h24, 32'hFFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 32'h24, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    // only the low byte lane is written
    pstrb <= 4'h1;
    apb(1'b1, 32'(OFF_PRIO0), 32'hFFFF);
    pstrb <= 4'hF;
    apb(1'b0, 32'(OFF_PRIO0), 32'h0);
    chk(rd, 32'h4477);
    chk({31'h0, er}, 32'h0);
    apb(1'b1, 32'(OFF_PRIO0), 32'h4444);
    apb(1'b1, 32'(OFF_IRQ_EN), 32'h3);
    flagWant <= 22'h080001;
    settle;
    chk(32'(srcRequest), 32'h1);
    chk({coreRequest, coreLevel}, 4'hC);
    apb(1'b1, 32'(OFF_PRIO0), 32'h7444);
    settle;
    chk(32'(coreLevel), 32'h7);
    apb(1'b1, 32'(OFF_PRIO0), 32'h0444);
    settle;
    chk({coreRequest, srcRequest}, 23'h0);
    apb(1'b1, 32'(OFF_ENABLE5), 32'h40);
    settle;
    chk(32'(srcRequest), 32'h80000);
    chk({coreRequest, coreLevel, irqOut}, 5'h19);
    apb(1'b0, 32'(OFF_IRQ_STAT), 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, 32'(OFF_IRQ_EN), 32'h0);
    settle;
    chk(32'(irqOut), 32'h0);
    flagWant <= '0;
    apb(1'b1, 32'(OFF_IRQ_CLR), 32'h3);
    apb(1'b0, 32'(OFF_IRQ_STAT), 32'h0);
    chk(rd, 32'h0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire

/* File: hw/iep_ctrl.sv */
// enable and priority control registers with APB slave and request gating
//
// Behaviour
// - enable 1 lets a source's request through, 0 blocks it
// - enable bits read/write, reset to 0 so sources 11 to 19 start masked
// - unimplemented enable and priority bits ignore writes and read zero
// - priority 3-bit levels 1..7, 7 highest, 0 disables the source
// - priority fields reset to 100, level four, all bits read/write
// - priority word 0: timer1 14-12, compare1 10-8, capture1 6-4, ext0 2-0
// - priority word 1: timer2 14-12, compare2 10-8, capture2 6-4, rest zero
// - priority word 2: uart1 rx 14-12, spi1 event 10-8, spi1 fault 6-4, timer3 2-0
// - enable word 3: charge-time 13, low-voltage 8, checksum 3, uart2/uart1 error 2/1
// - enable word 5: only bit 6, usb module enable
// - each source has a pending flag input; the enables gate those of sources 11 to 19
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module iep_ctrl
  import iep_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] srcFlag,
  output logic [NUM_SRC-1:0] srcRequest,
  output logic coreRequest,
  output logic [2:0] coreLevel,
  output logic irqOut
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [15:0] enable2_ff, enable3_ff, enable5_ff;
  logic [15:0] prio0_ff, prio1_ff, prio2_ff;
  logic [NUM_EVT-1:0] irqStat_ff, irqEn_ff;
  logic [31:0] prdata_ff;
  logic [2:0] coreLevel_ff;
  logic [NUM_SRC-1:0] srcRequest_ff;
  logic accessPhase, wrStrobe, rdStrobe, addrHit, lowLanes;
  logic [ADDR_W-1:0] regAddr;
  logic [15:0] nxt_wordData;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] res;
    res = old;
    if (strb[0]) res[7:0] = wd[7:0];
    if (strb[1]) res[15:8] = wd[15:8];
    return res & mask;
  endfunction

  assign accessPhase = psel && penable;
  assign regAddr = paddr[ADDR_W-1:0];
  // upper address bits must be zero so that no alias reaches a register
  assign addrHit = (paddr[31:ADDR_W] == '0) && (paddr[1:0] == 2'h0) && (regAddr <= OFF_IRQ_EN);
  assign wrStrobe = accessPhase && pwrite && addrHit;
  assign rdStrobe = accessPhase && !pwrite && addrHit;
  // registers are 16 bits wide: only byte lanes 0 and 1 carry data
  assign lowLanes = |pstrb[1:0];
  assign nxt_wordData = pwdata[15:0];
  assign pready = 1'b1;
  assign pslverr = accessPhase && !addrHit;

  // ---------------------------------------------------------------
  // enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable2_ff <= RST_ENABLE;
      enable3_ff <= RST_ENABLE;
      enable5_ff <= RST_ENABLE;
    end else if (wrStrobe && lowLanes) begin
      if (regAddr == OFF_ENABLE2) enable2_ff <= merge16(enable2_ff, nxt_wordData, pstrb[1:0], MASK_ENABLE2);
      if (regAddr == OFF_ENABLE3) enable3_ff <= merge16(enable3_ff, nxt_wordData, pstrb[1:0], MASK_ENABLE3);
      if (regAddr == OFF_ENABLE5) enable5_ff <= merge16(enable5_ff, nxt_wordData, pstrb[1:0], MASK_ENABLE5);
    end
  end

  // ---------------------------------------------------------------
  // priority registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prio0_ff <= RST_PRIO & MASK_PRIO0;
      prio1_ff <= RST_PRIO & MASK_PRIO1;
      prio2_ff <= RST_PRIO & MASK_PRIO2;
    end else if (wrStrobe) begin
      if (regAddr == OFF_PRIO0) prio0_ff <= merge16(prio0_ff, nxt_wordData, pstrb[1:0], MASK_PRIO0);
      if (regAddr == OFF_PRIO1) prio1_ff <= merge16(prio1_ff, nxt_wordData, pstrb[1:0], MASK_PRIO1);
      if (regAddr == OFF_PRIO2) prio2_ff <= merge16(prio2_ff, nxt_wordData, pstrb[1:0], MASK_PRIO2);
    end
  end

  // ---------------------------------------------------------------
  // source map: enable bit and level per source
  // ---------------------------------------------------------------
  // sources: 0 timer1,1 compare1,2 capture1,3 ext0,4 timer2,5 compare2,6 capture2,
  // 7 uart1 rx,8 spi1 event,9 spi1 fault,10 timer3 (enables live in words not held here,
  // so they stay enabled by level only), 11 calendar,12 i2c2 master,13 i2c2 slave,
  // 14 charge-time,15 low-voltage,16 checksum,17 uart2 err,18 uart1 err,19 usb
  logic [NUM_SRC-1:0] srcEnable;
  logic [3*NUM_SRC-1:0] srcLevel;
  always_comb begin
    srcEnable = '0;
    srcLevel = '0;
    srcEnable[10:0] = '1;
    srcLevel[3*0 +: 3] = prio0_ff[14:12];
    srcLevel[3*1 +: 3] = prio0_ff[10:8];
    srcLevel[3*2 +: 3] = prio0_ff[6:4];
    srcLevel[3*3 +: 3] = prio0_ff[2:0];
    srcLevel[3*4 +: 3] = prio1_ff[14:12];
    srcLevel[3*5 +: 3] = prio1_ff[10:8];
    srcLevel[3*6 +: 3] = prio1_ff[6:4];
    srcLevel[3*7 +: 3] = prio2_ff[14:12];
    srcLevel[3*8 +: 3] = prio2_ff[10:8];
    srcLevel[3*9 +: 3] = prio2_ff[6:4];
    srcLevel[3*10 +: 3] = prio2_ff[2:0];
    srcEnable[11] = enable2_ff[14];
    srcEnable[12] = enable2_ff[2];
    srcEnable[13] = enable2_ff[1];
    srcEnable[14] = enable3_ff[13];
    srcEnable[15] = enable3_ff[8];
    srcEnable[16] = enable3_ff[3];
    srcEnable[17] = enable3_ff[2];
    srcEnable[18] = enable3_ff[1];
    srcEnable[19] = enable5_ff[6];
    // level for sources whose priority word is outside this block: default four
    for (int i = 11; i < NUM_SRC; i++) begin
      srcLevel[3*i +: 3] = RST_PRIO[2:0] | 3'h4;
    end
  end

  // ---------------------------------------------------------------
  // request gating and level report
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] nxt_srcRequest;
  logic [2:0] nxt_coreLevel;
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      nxt_srcRequest[i] = srcFlag[i] && srcEnable[i] && (srcLevel[3*i +: 3] != 3'h0);
    end
  end

  iep_prio_max #(.N(NUM_SRC)) uMax (
    .srcActive(nxt_srcRequest),
    .srcLevel(srcLevel),
    .topLevel(nxt_coreLevel)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      srcRequest_ff <= '0;
      coreLevel_ff <= 3'h0;
    end else begin
      srcRequest_ff <= nxt_srcRequest;
      coreLevel_ff <= nxt_coreLevel;
    end
  end
  assign srcRequest = srcRequest_ff;
  assign coreLevel = coreLevel_ff;
  assign coreRequest = |srcRequest_ff;

  // ---------------------------------------------------------------
  // block's own interrupt: new request, level rise
  // ---------------------------------------------------------------
  logic [NUM_EVT-1:0] evt;
  assign evt[EVT_NEW_REQ] = |(nxt_srcRequest & ~srcRequest_ff);
  assign evt[EVT_LEVEL_UP] = nxt_coreLevel > coreLevel_ff;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_ff <= '0;
    end else begin
      // set wins over a clear in the same cycle
      irqStat_ff <= (irqStat_ff & ~((wrStrobe && regAddr == OFF_IRQ_CLR) ? pwdata[NUM_EVT-1:0] : '0)) | evt;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqEn_ff <= '0;
    end else if (wrStrobe && regAddr == OFF_IRQ_EN && pstrb[0]) begin
      irqEn_ff <= pwdata[NUM_EVT-1:0];
    end
  end
  assign irqOut = |(irqStat_ff & irqEn_ff);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] nxt_prdata;
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (regAddr)
      OFF_ENABLE2: nxt_prdata[15:0] = enable2_ff;
      OFF_ENABLE3: nxt_prdata[15:0] = enable3_ff;
      OFF_ENABLE5: nxt_prdata[15:0] = enable5_ff;
      OFF_PRIO0: nxt_prdata[15:0] = prio0_ff;
      OFF_PRIO1: nxt_prdata[15:0] = prio1_ff;
      OFF_PRIO2: nxt_prdata[15:0] = prio2_ff;
      OFF_IRQ_STAT: nxt_prdata[NUM_EVT-1:0] = irqStat_ff;
      OFF_IRQ_EN: nxt_prdata[NUM_EVT-1:0] = irqEn_ff;
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end
  // read data registered in setup so it is stable through the access phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= addrHit ? nxt_prdata : 32'h0000_0000;
    end
  end
  assign prdata = prdata_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_ENABLE_BLOCKS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable3_ff[13] |=> !srcRequest_ff[14] || $past(enable3_ff[13]) == 1'b1)
    else $error("disabled source produced a request");
  AST_UNIMP_ENABLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (enable2_ff & ~MASK_ENABLE2) == 16'h0 && (enable5_ff & ~MASK_ENABLE5) == 16'h0)
    else $error("unimplemented enable bit set");
  AST_UNIMP_PRIO: assert property (@(posedge sys_clk) disable iff (!reset_n)
    prio1_ff[3:0] == 4'h0 && prio0_ff[15] == 1'b0 && prio2_ff[11] == 1'b0)
    else $error("unimplemented priority bit set");
  AST_ZERO_DISABLES: assert property (@(posedge sys_clk) disable iff (!reset_n)
    prio0_ff[14:12] == 3'h0 |=> !srcRequest_ff[0])
    else $error("priority zero source requested");
  AST_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    srcFlag[19] && enable5_ff[6] |=> srcRequest_ff[19])
    else $error("enabled flagged source not requested");
  AST_FLAG_NEEDED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !srcFlag[16] |=> !srcRequest_ff[16])
    else $error("request without flag");
  AST_LEVEL_TOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    srcRequest_ff[0] |-> coreLevel_ff >= $past(prio0_ff[14:12]))
    else $error("reported level below active source");
  AST_WRITE_ENABLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wrStrobe && regAddr == OFF_ENABLE3 && pstrb[1] |=> enable3_ff[8] == $past(pwdata[8]))
    else $error("enable write lost");
  AST_WRITE_PRIO: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wrStrobe && regAddr == OFF_PRIO2 && pstrb[0] |=> prio2_ff[2:0] == $past(pwdata[2:0]))
    else $error("priority write lost");
  AST_NO_LEVEL_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !coreRequest |-> coreLevel_ff == 3'h0)
    else $error("level shown with no request");

  // ---------------------------------------------------------------
  // read path and event checks
  // ---------------------------------------------------------------
  // read data was latched in setup; it must match the register at the access edge
  AST_READ_ENABLE2: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && regAddr == OFF_ENABLE2 |-> prdata_ff == {16'h0000, enable2_ff})
    else $error("read data differs from enable word 2");
  AST_READ_ENABLE3: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && regAddr == OFF_ENABLE3 |-> prdata_ff == {16'h0000, enable3_ff})
    else $error("read data differs from enable word 3");
  AST_READ_ENABLE5: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && regAddr == OFF_ENABLE5 |-> prdata_ff == {16'h0000, enable5_ff})
    else $error("read data differs from enable word 5");
  AST_READ_PRIO0: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && regAddr == OFF_PRIO0 |-> prdata_ff == {16'h0000, prio0_ff})
    else $error("read data differs from priority word 0");
  AST_READ_PRIO1: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && regAddr == OFF_PRIO1 |-> prdata_ff == {16'h0000, prio1_ff})
    else $error("read data differs from priority word 1");
  AST_READ_PRIO2: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe && regAddr == OFF_PRIO2 |-> prdata_ff == {16'h0000, prio2_ff})
    else $error("read data differs from priority word 2");
  AST_READ_STABLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rdStrobe |=> $stable(prdata_ff))
    else $error("read data moved after the access phase");
  AST_UNMAPPED_IGNORED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    accessPhase && !addrHit |=> $stable(enable2_ff) && $stable(enable3_ff) && $stable(prio0_ff))
    else $error("unmapped access changed a register");
  AST_UNIMP_REST: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (enable3_ff & ~MASK_ENABLE3) == 16'h0 && (prio0_ff & ~MASK_PRIO0) == 16'h0 && (prio2_ff & ~MASK_PRIO2) == 16'h0)
    else $error("unimplemented bit set");
  AST_HIGH_WINS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    srcRequest_ff[0] && $past(prio0_ff[14:12]) == 3'h7 |-> coreLevel_ff == 3'h7)
    else $error("highest level not reported");
  AST_REQ_LEVEL_NONZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
    coreRequest |-> coreLevel_ff != 3'h0)
    else $error("request shown with level zero");
  AST_I2C_BLOCKED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable2_ff[2] |=> !srcRequest_ff[12])
    else $error("masked source produced a request");
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    evt[EVT_NEW_REQ] |=> irqStat_ff[EVT_NEW_REQ])
    else $error("new request event lost");
  AST_LEVEL_UP_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    evt[EVT_LEVEL_UP] |=> irqStat_ff[EVT_LEVEL_UP])
    else $error("level rise event lost");
endmodule // iep_ctrl
`default_nettype wire

/* File: hw/iep_pkg.sv */
// package: register map, field layout and reset values of the enable/priority block
package iep_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_ENABLE2 = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_ENABLE3 = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_ENABLE5 = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_PRIO0 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_PRIO1 = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_PRIO2 = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 6'h20;
  // implemented-bit masks; everything else reads 0 and ignores writes
  localparam logic [15:0] MASK_ENABLE2 = 16'h4006;
  localparam logic [15:0] MASK_ENABLE3 = 16'h210E;
  localparam logic [15:0] MASK_ENABLE5 = 16'h0040;
  localparam logic [15:0] MASK_PRIO0 = 16'h7777;
  localparam logic [15:0] MASK_PRIO1 = 16'h7770;
  localparam logic [15:0] MASK_PRIO2 = 16'h7777;
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_PRIO = 16'h4444;
  localparam int NUM_SRC = 22;
  localparam int NUM_EVT = 2;
  // event bits in the status word
  localparam int EVT_NEW_REQ = 0;
  localparam int EVT_LEVEL_UP = 1;
endpackage : iep_pkg

/* File: hw/iep_prio_max.sv */
// highest-level selector over all gated sources
`timescale 1ns/10ps
`default_nettype none
module iep_prio_max
  import iep_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input wire logic [N-1:0] srcActive,
  input wire logic [3*N-1:0] srcLevel,
  output logic [2:0] topLevel
);
  always_comb begin
    topLevel = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (srcActive[i] && (srcLevel[3*i +: 3] > topLevel)) begin
        topLevel = srcLevel[3*i +: 3];
      end
    end
  end
endmodule // iep_prio_max
`default_nettype wire
